// ==== rtl/mul_port_pkg.sv ====
// Purpose: constants and types for the multiply / port read / add-one execution block
// Assumes: AHB-Lite register slave, word registers, one clock
// Notes: register offsets are byte addresses
// Functional notes
// RULE_01: signed multiply forms full signed double-length product
// RULE_02: byte multiply puts product in accumulator_high:low
// RULE_03: word multiply puts product in data_extension_reg:accumulator_word
// RULE_04: carry/overflow set when upper half is significant
// RULE_05: multiply keeps direction, irq enable and trap
// RULE_06: port read loads accumulator_low or accumulator_word
// RULE_07: immediate port number reaches ports 0 to 255
// RULE_08: data_extension_reg port number covers full 16 bits
// RULE_09: port reads leave every flag unchanged
// RULE_10: add-one increments byte or word operand in place
// RULE_11: add-one updates aux, parity, sign, zero only
// RULE_12: block read: port from data_extension_reg, offset dest_pointer
// RULE_13: block read memory write always uses extra_segment
// RULE_14: dest_pointer steps after each block transfer
// RULE_15: step is 1 for bytes, 2 for words
// RULE_16: repeat prefix makes block read repeat
// RULE_17: direction clear steps up, set steps down
package mul_port_pkg;
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_ACC     = 8'h04;
    localparam logic [7:0] ADDR_DEXT    = 8'h08;
    localparam logic [7:0] ADDR_DPTR    = 8'h0C;
    localparam logic [7:0] ADDR_ESEG    = 8'h10;
    localparam logic [7:0] ADDR_FLAGS   = 8'h14;
    localparam logic [7:0] ADDR_OPER    = 8'h18;
    localparam logic [7:0] ADDR_RCNT    = 8'h1C;
    localparam logic [7:0] ADDR_STATUS  = 8'h20;

    localparam int CTL_OP_LSB   = 0;
    localparam int CTL_WORD_BIT = 2;
    localparam int CTL_DXP_BIT  = 3;
    localparam int CTL_REP_BIT  = 4;
    localparam int CTL_TGT_LSB  = 5;
    localparam int CTL_IMM_LSB  = 8;

    localparam int FLG_CF = 0;
    localparam int FLG_PF = 2;
    localparam int FLG_AF = 4;
    localparam int FLG_ZF = 6;
    localparam int FLG_SF = 7;
    localparam int FLG_TF = 8;
    localparam int FLG_IF = 9;
    localparam int FLG_DF = 10;
    localparam int FLG_OF = 11;

    localparam logic [15:0] REG_RST   = 16'h0000;
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [1:0]  HSIZE_WORD = 2'h2;

    typedef enum logic [1:0] {OP_MUL, OP_IN, OP_INC, OP_BLKIN} op_e;

    typedef struct packed {
        logic        valid;
        logic        word;
        logic [15:0] addr;
    } io_req_s;

    typedef struct packed {
        logic        valid;
        logic        word;
        logic [15:0] seg;
        logic [15:0] off;
        logic [15:0] data;
    } mem_req_s;
endpackage

// ==== rtl/mul_port_exec.sv ====
// Purpose: execution of signed multiply, port read, add-one and block port read
// Assumes: bus unit on the same clock answers io and memory requests with acks
// Notes: registers reached over AHB-Lite, reads take one wait state
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mul_port_exec (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    output mul_port_pkg::io_req_s      io_req,
    input  wire logic                  io_ack,
    input  wire logic [15:0]           io_rdata,
    output mul_port_pkg::mem_req_s     mem_req,
    input  wire logic                  mem_ack
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_IO, ST_MEM} state_e;

    state_e                 state_r;
    logic                   ph_v_r;
    logic                   ph_w_r;
    logic                   ph_sz_r;
    logic [7:0]             ph_a_r;
    logic                   rd_ok_r;
    logic [31:0]            hrdata_r;
    logic [15:0]            acc_r;
    logic [15:0]            dext_r;
    logic [15:0]            dptr_r;
    logic [15:0]            eseg_r;
    logic [15:0]            flags_r;
    logic [15:0]            oper_r;
    logic [15:0]            rcnt_r;
    logic [15:0]            ctl_r;
    mul_port_pkg::io_req_s  io_r;
    mul_port_pkg::mem_req_s mem_r;

    logic                   bus_wr;
    logic                   start;
    logic                   io_done;
    logic                   mem_done;
    mul_port_pkg::op_e      op;
    logic                   wsz;
    logic                   rep;
    logic [1:0]             tgt;
    logic signed [15:0]     prod_b;
    logic signed [31:0]     prod_w;
    logic                   ovf;
    logic [15:0]            inc_old;
    logic [15:0]            inc_nxt;
    logic [15:0]            step;
    logic [15:0]            rcnt_nxt;

    function automatic logic [15:0] tgt_val(input logic [1:0] sel, input logic [15:0] a,
                                            input logic [15:0] d, input logic [15:0] p,
                                            input logic [15:0] o);
        case (sel)
            2'h0:    tgt_val = a;
            2'h1:    tgt_val = d;
            2'h2:    tgt_val = p;
            default: tgt_val = o;
        endcase
    endfunction

    assign op       = mul_port_pkg::op_e'(ctl_r[mul_port_pkg::CTL_OP_LSB +: 2]);
    assign wsz      = ctl_r[mul_port_pkg::CTL_WORD_BIT];
    assign rep      = ctl_r[mul_port_pkg::CTL_REP_BIT];
    assign tgt      = ctl_r[mul_port_pkg::CTL_TGT_LSB +: 2];
    assign bus_wr   = ph_v_r & ph_w_r & ph_sz_r;
    assign start    = bus_wr & (ph_a_r == mul_port_pkg::ADDR_CTRL) & (state_r == ST_IDLE);
    assign io_done  = (state_r == ST_IO) & io_ack;
    assign mem_done = (state_r == ST_MEM) & mem_ack;
    assign step     = wsz ? mul_port_pkg::STEP_WORD : mul_port_pkg::STEP_BYTE; // RULE_15
    assign rcnt_nxt = rcnt_r - 16'h0001;

    // full signed products of source and accumulator
    assign prod_b  = $signed(oper_r[7:0]) * $signed(acc_r[7:0]); // RULE_01
    assign prod_w  = $signed(oper_r) * $signed(acc_r); // RULE_01
    assign ovf     = wsz ? (prod_w[31:16] != {16{prod_w[15]}})
                         : (prod_b[15:8] != {8{prod_b[7]}}); // RULE_04
    assign inc_old = tgt_val(tgt, acc_r, dext_r, dptr_r, oper_r);
    assign inc_nxt = wsz ? inc_old + 16'h0001
                         : {inc_old[15:8], inc_old[7:0] + 8'h01}; // RULE_10

    // bus slave
    assign hreadyout = ~(ph_v_r & ~ph_w_r & ~rd_ok_r);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ph_v_r  <= 1'b0;
            ph_w_r  <= 1'b0;
            ph_sz_r <= 1'b0;
            ph_a_r  <= 8'h00;
        end else if (hready) begin
            ph_v_r  <= hsel & htrans[1];
            ph_w_r  <= hwrite;
            ph_sz_r <= (hsize[1:0] == mul_port_pkg::HSIZE_WORD);
            ph_a_r  <= haddr[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ok_r  <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            rd_ok_r <= ph_v_r & ~ph_w_r & ~rd_ok_r;
            if (ph_v_r & ~ph_w_r & ~rd_ok_r) begin
                case (ph_a_r)
                    mul_port_pkg::ADDR_CTRL:   hrdata_r <= {16'h0000, ctl_r};
                    mul_port_pkg::ADDR_ACC:    hrdata_r <= {16'h0000, acc_r};
                    mul_port_pkg::ADDR_DEXT:   hrdata_r <= {16'h0000, dext_r};
                    mul_port_pkg::ADDR_DPTR:   hrdata_r <= {16'h0000, dptr_r};
                    mul_port_pkg::ADDR_ESEG:   hrdata_r <= {16'h0000, eseg_r};
                    mul_port_pkg::ADDR_FLAGS:  hrdata_r <= {16'h0000, flags_r};
                    mul_port_pkg::ADDR_OPER:   hrdata_r <= {16'h0000, oper_r};
                    mul_port_pkg::ADDR_RCNT:   hrdata_r <= {16'h0000, rcnt_r};
                    mul_port_pkg::ADDR_STATUS: hrdata_r <= {31'h0, state_r != ST_IDLE};
                    default:                   hrdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // sequencing and bus unit requests
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            ctl_r   <= mul_port_pkg::REG_RST;
            io_r    <= '0;
            mem_r   <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        ctl_r   <= hwdata[15:0];
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    io_r.word <= wsz;
                    if (op == mul_port_pkg::OP_IN) begin
                        io_r.valid <= 1'b1;
                        if (ctl_r[mul_port_pkg::CTL_DXP_BIT]) begin
                            io_r.addr <= dext_r; // RULE_08
                        end else begin
                            io_r.addr <= {8'h00, ctl_r[mul_port_pkg::CTL_IMM_LSB +: 8]}; // RULE_07
                        end
                        state_r <= ST_IO;
                    end else if (op == mul_port_pkg::OP_BLKIN) begin
                        if (rep && rcnt_r == 16'h0000) begin
                            state_r <= ST_IDLE;
                        end else begin
                            io_r.valid <= 1'b1;
                            io_r.addr  <= dext_r; // RULE_12
                            state_r    <= ST_IO;
                        end
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_IO: begin
                    if (io_ack) begin
                        io_r.valid <= 1'b0;
                        if (op == mul_port_pkg::OP_BLKIN) begin
                            mem_r.valid <= 1'b1;
                            mem_r.word  <= wsz;
                            mem_r.seg   <= eseg_r; // RULE_13
                            mem_r.off   <= dptr_r; // RULE_12
                            mem_r.data  <= io_rdata;
                            state_r     <= ST_MEM;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_MEM: begin
                    if (mem_ack) begin
                        mem_r.valid <= 1'b0;
                        if (rep && rcnt_nxt != 16'h0000) begin
                            io_r.valid <= 1'b1; // RULE_16
                            state_r    <= ST_IO;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign io_req  = io_r;
    assign mem_req = mem_r;

    // architectural registers; software writes only while idle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_r   <= mul_port_pkg::REG_RST;
            dext_r  <= mul_port_pkg::REG_RST;
            dptr_r  <= mul_port_pkg::REG_RST;
            eseg_r  <= mul_port_pkg::REG_RST;
            flags_r <= mul_port_pkg::FLAGS_RST;
            oper_r  <= mul_port_pkg::REG_RST;
            rcnt_r  <= mul_port_pkg::REG_RST;
        end else if (state_r == ST_EXEC && op == mul_port_pkg::OP_MUL) begin
            if (wsz) begin
                {dext_r, acc_r} <= prod_w; // RULE_03
            end else begin
                acc_r <= prod_b; // RULE_02
            end
            flags_r[mul_port_pkg::FLG_CF] <= ovf; // RULE_04
            flags_r[mul_port_pkg::FLG_OF] <= ovf; // RULE_04
        end else if (state_r == ST_EXEC && op == mul_port_pkg::OP_INC) begin
            case (tgt)
                2'h0:    acc_r  <= inc_nxt;
                2'h1:    dext_r <= inc_nxt;
                2'h2:    dptr_r <= inc_nxt;
                default: oper_r <= inc_nxt;
            endcase
            flags_r[mul_port_pkg::FLG_AF] <= (inc_old[3:0] == 4'hF); // RULE_11
            flags_r[mul_port_pkg::FLG_PF] <= ~^inc_nxt[7:0]; // RULE_11
            flags_r[mul_port_pkg::FLG_SF] <= wsz ? inc_nxt[15] : inc_nxt[7]; // RULE_11
            flags_r[mul_port_pkg::FLG_ZF] <= wsz ? (inc_nxt == 16'h0000)
                                                 : (inc_nxt[7:0] == 8'h00); // RULE_11
        end else if (io_done && op == mul_port_pkg::OP_IN) begin
            if (wsz) begin
                acc_r <= io_rdata; // RULE_06
            end else begin
                acc_r <= {acc_r[15:8], io_rdata[7:0]}; // RULE_06
            end
        end else if (mem_done) begin
            if (flags_r[mul_port_pkg::FLG_DF]) begin
                dptr_r <= dptr_r - step; // RULE_17
            end else begin
                dptr_r <= dptr_r + step; // RULE_14
            end
            if (rep) begin
                rcnt_r <= rcnt_nxt; // RULE_16
            end
        end else if (bus_wr && state_r == ST_IDLE) begin
            case (ph_a_r)
                mul_port_pkg::ADDR_ACC:   acc_r   <= hwdata[15:0];
                mul_port_pkg::ADDR_DEXT:  dext_r  <= hwdata[15:0];
                mul_port_pkg::ADDR_DPTR:  dptr_r  <= hwdata[15:0];
                mul_port_pkg::ADDR_ESEG:  eseg_r  <= hwdata[15:0];
                mul_port_pkg::ADDR_FLAGS: flags_r <= hwdata[15:0];
                mul_port_pkg::ADDR_OPER:  oper_r  <= hwdata[15:0];
                mul_port_pkg::ADDR_RCNT:  rcnt_r  <= hwdata[15:0];
                default:                  acc_r   <= acc_r;
            endcase
        end
    end

    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_mul(logic w);
        state_r == ST_EXEC && op == mul_port_pkg::OP_MUL && wsz == w;
    endsequence

    sequence s_inc;
        state_r == ST_EXEC && op == mul_port_pkg::OP_INC && tgt == 2'h0 && wsz;
    endsequence

    mul_byte_a: assert property (s_mul(1'b0) |=> acc_r == $past(prod_b)) // RULE_02
        else $error("byte product wrong");
    mul_word_a: assert property (s_mul(1'b1) |=> {dext_r, acc_r} == $past(prod_w)) // RULE_03
        else $error("word product wrong");
    mul_flags_a: assert property (s_mul(wsz) |=> flags_r[mul_port_pkg::FLG_CF] ==
        $past(ovf) && flags_r[mul_port_pkg::FLG_OF] == $past(ovf)) // RULE_04
        else $error("multiply carry or overflow wrong");
    mul_keep_a: assert property (s_mul(wsz) |=> flags_r[10:8] == $past(flags_r[10:8])) // RULE_05
        else $error("multiply changed control flags");
    port_imm_a: assert property (state_r == ST_EXEC && op == mul_port_pkg::OP_IN &&
        !ctl_r[mul_port_pkg::CTL_DXP_BIT] |=> io_req.valid && io_req.addr[15:8] == 8'h00) // RULE_07
        else $error("immediate port above 255");
    port_flags_a: assert property ((state_r == ST_IO || state_r == ST_MEM) |=>
        flags_r == $past(flags_r)) // RULE_09
        else $error("port read changed flags");
    blk_seg_a: assert property (mem_req.valid |-> mem_req.seg == eseg_r) // RULE_13
        else $error("block write not in extra segment");
    blk_step_a: assert property (mem_done |=> dptr_r == ($past(flags_r[mul_port_pkg::FLG_DF])
        ? $past(dptr_r) - $past(step) : $past(dptr_r) + $past(step))) // RULE_14
        else $error("dest pointer step wrong");
    inc_word_a: assert property (s_inc |=> acc_r == $past(acc_r) + 16'h0001 &&
        flags_r[mul_port_pkg::FLG_CF] == $past(flags_r[mul_port_pkg::FLG_CF])) // RULE_10
        else $error("add-one wrong");
endmodule
`default_nettype wire

// ==== testbench/bus_unit_model.sv ====
// Purpose: bus unit model answering the block's io and memory requests
// Assumes: same clock as the block, acks are one-cycle pulses after wait_cycles
// Notes: port data is the port address xor a fixed pattern, inverted on every cycle without an ack
`timescale 1ns/1ns
`default_nettype none
module bus_unit_model (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic [3:0]             wait_cycles,
    input  wire mul_port_pkg::io_req_s  io_req,
    input  wire mul_port_pkg::mem_req_s mem_req,
    output logic                        io_ack,
    output logic [15:0]                 io_rdata,
    output logic                        mem_ack,
    output mul_port_pkg::mem_req_s      last_mem,
    output logic [15:0]                 last_port,
    output logic [7:0]                  mem_count
);
    logic [3:0] io_cnt;
    logic [3:0] mem_cnt;

    // port cycles: answer after the chosen wait, data line toggles outside the ack
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            io_ack <= 1'b0;
            io_cnt <= 4'h0;
            io_rdata <= 16'hFFFF;
            last_port <= 16'h0000;
        end else if (io_req.valid && !io_ack && io_cnt == wait_cycles) begin
            io_ack <= 1'b1;
            io_cnt <= 4'h0;
            io_rdata <= io_req.addr ^ 16'hC35A;
            last_port <= io_req.addr;
        end else begin
            io_ack <= 1'b0;
            io_cnt <= (io_req.valid && !io_ack) ? io_cnt + 4'h1 : 4'h0;
            io_rdata <= ~io_rdata;
        end
    end

    // memory cycles: record each accepted write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_cnt <= 4'h0;
            last_mem <= '0;
            mem_count <= 8'h00;
        end else if (mem_req.valid && !mem_ack && mem_cnt == wait_cycles) begin
            mem_ack <= 1'b1;
            mem_cnt <= 4'h0;
            last_mem <= mem_req;
            mem_count <= mem_count + 8'h01;
        end else begin
            mem_ack <= 1'b0;
            mem_cnt <= (mem_req.valid && !mem_ack) ? mem_cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/mul_port_exec_bench.sv ====
// Purpose: self-checking bench for the multiply / port read / add-one block
// Assumes: one AHB-Lite master, bus unit model on the io and memory side
// Notes: expectations are worked out here from the operands
`timescale 1ns/1ns
`default_nettype none
module mul_port_exec_bench;
    logic                   ref_clk;
    logic                   rst;
    logic                   hsel;
    logic [31:0]            haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [2:0]             hsize;
    logic [31:0]            hwdata;
    logic                   hreadyout;
    logic                   hresp;
    logic [31:0]            hrdata;
    logic                   io_ack;
    logic [15:0]            io_rdata;
    logic                   mem_ack;
    logic [3:0]             wait_cycles;
    logic [15:0]            last_port;
    logic [7:0]             mem_count;
    mul_port_pkg::io_req_s  io_req;
    mul_port_pkg::mem_req_s mem_req;
    mul_port_pkg::mem_req_s last_mem;
    int                     errors;
    int                     total_checks;

    mul_port_exec mul_port_exec_inst (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .io_req(io_req), .io_ack(io_ack),
        .io_rdata(io_rdata), .mem_req(mem_req), .mem_ack(mem_ack));
    bus_unit_model bus_unit_model_inst (.ref_clk(ref_clk), .rst(rst), .wait_cycles(wait_cycles),
        .io_req(io_req), .mem_req(mem_req), .io_ack(io_ack), .io_rdata(io_rdata),
        .mem_ack(mem_ack), .last_mem(last_mem), .last_port(last_port), .mem_count(mem_count));

    task automatic results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge ref_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                errors++;
                $display("Error at %0t: hready stuck low", $time);
                results();
            end
            @(negedge ref_clk);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] wd,
                        output logic [15:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        wait_ready();
        @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        wait_ready();
        rd = hrdata[15:0];
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] x;
        xfer(a, 1'b1, d, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        xfer(a, 1'b0, 16'h0000, d);
    endtask

    // start a command and poll busy until it drops
    task automatic run(input logic [1:0] op, input logic wd, input logic dxp, input logic rep,
                       input logic [1:0] tgt, input logic [7:0] imm);
        logic [15:0] s;
        int          n;
        wr(mul_port_pkg::ADDR_CTRL, {imm, 1'b0, tgt, rep, dxp, wd, op});
        s = 16'h0001;
        n = 0;
        while (s[0] !== 1'b0) begin
            n++;
            if (n > 60) begin
                errors++;
                $display("Error at %0t: busy never cleared", $time);
                results();
            end
            rd(mul_port_pkg::ADDR_STATUS, s);
        end
    endtask

    task automatic test_reset();
        logic [15:0] v;
        rd(mul_port_pkg::ADDR_ACC, v);
        check(v, mul_port_pkg::REG_RST, "acc reset");
        rd(mul_port_pkg::ADDR_FLAGS, v);
        check(v, mul_port_pkg::FLAGS_RST, "flags reset");
        rd(8'h40, v);
        check(v, 16'h0000, "unmapped read");
        check({15'h0000, hresp}, 16'h0000, "okay response");
        $display("test_reset done");
    endtask

    task automatic mul_case(input logic wd, input logic [15:0] acc, input logic [15:0] src);
        logic signed [31:0] p;
        logic [15:0]        v;
        logic               sig;
        if (wd) p = $signed(src) * $signed(acc);
        else p = $signed(src[7:0]) * $signed(acc[7:0]);
        sig = wd ? (p[31:16] != {16{p[15]}}) : (p[15:8] != {8{p[7]}});
        wr(mul_port_pkg::ADDR_ACC, acc);
        wr(mul_port_pkg::ADDR_DEXT, 16'h5A5A);
        wr(mul_port_pkg::ADDR_OPER, src);
        wr(mul_port_pkg::ADDR_FLAGS, sig ? 16'h0700 : 16'h0F01);
        run(2'h0, wd, 1'b0, 1'b0, 2'h0, 8'h00);
        rd(mul_port_pkg::ADDR_ACC, v);
        check(v, p[15:0], "product low");
        rd(mul_port_pkg::ADDR_DEXT, v);
        check(v, wd ? p[31:16] : 16'h5A5A, "product high");
        rd(mul_port_pkg::ADDR_FLAGS, v);
        check(v & 16'h0F01, {4'h0, sig, 3'h7, 7'h00, sig}, "mul flags");
    endtask

    task automatic test_mul();
        mul_case(1'b0, 16'hAB7F, 16'h007F);
        mul_case(1'b0, 16'h00FD, 16'h0005);
        mul_case(1'b0, 16'h0080, 16'h0080);
        mul_case(1'b1, 16'h7FFF, 16'h0002);
        mul_case(1'b1, 16'hFFFF, 16'hFFFF);
        mul_case(1'b1, 16'h8000, 16'h8000);
        $display("test_mul done");
    endtask

    task automatic in_case(input logic wd, input logic dxp, input logic [7:0] imm,
                           input logic [15:0] dx, input logic [3:0] wt);
        logic [15:0] v;
        logic [15:0] port;
        logic [15:0] pv;
        port = dxp ? dx : {8'h00, imm};
        pv = port ^ 16'hC35A;
        wait_cycles <= wt;
        wr(mul_port_pkg::ADDR_ACC, 16'h9966);
        wr(mul_port_pkg::ADDR_DEXT, dx);
        wr(mul_port_pkg::ADDR_FLAGS, 16'h0FD5);
        run(2'h1, wd, dxp, 1'b0, 2'h0, imm);
        check(last_port, port, "port address");
        rd(mul_port_pkg::ADDR_ACC, v);
        check(v, wd ? pv : {8'h99, pv[7:0]}, "port data");
        rd(mul_port_pkg::ADDR_FLAGS, v);
        check(v, 16'h0FD5, "port read flags");
    endtask

    task automatic test_in();
        in_case(1'b0, 1'b0, 8'hFF, 16'h1234, 4'h0);
        in_case(1'b0, 1'b0, 8'h00, 16'hFFFF, 4'h2);
        in_case(1'b1, 1'b1, 8'h00, 16'hFFFF, 4'h3);
        in_case(1'b0, 1'b1, 8'hAB, 16'h0100, 4'h0);
        $display("test_in done");
    endtask

    task automatic inc_case(input logic [1:0] tgt, input logic wd, input logic [15:0] v0);
        logic [7:0]  a;
        logic [15:0] v;
        logic [15:0] r;
        logic [15:0] fx;
        a = (tgt == 2'h0) ? mul_port_pkg::ADDR_ACC : (tgt == 2'h1) ? mul_port_pkg::ADDR_DEXT :
            (tgt == 2'h2) ? mul_port_pkg::ADDR_DPTR : mul_port_pkg::ADDR_OPER;
        r = wd ? v0 + 16'h0001 : {v0[15:8], v0[7:0] + 8'h01};
        fx = {5'h00, 3'h7, (wd ? r[15] : r[7]), (wd ? r == 16'h0000 : r[7:0] == 8'h00), 1'b0,
              (v0[3:0] == 4'hF), 1'b0, ~^r[7:0], 1'b0, 1'b1};
        wr(a, v0);
        wr(mul_port_pkg::ADDR_FLAGS, 16'h0701 | (~fx & 16'h00D4));
        run(2'h2, wd, 1'b0, 1'b0, tgt, 8'h00);
        rd(a, v);
        check(v, r, "add-one result");
        rd(mul_port_pkg::ADDR_FLAGS, v);
        check(v & 16'h07D5, fx, "add-one flags");
    endtask

    task automatic test_inc();
        inc_case(2'h0, 1'b1, 16'hFFFF);
        inc_case(2'h1, 1'b0, 16'h127F);
        inc_case(2'h2, 1'b1, 16'h00FF);
        inc_case(2'h3, 1'b0, 16'hA5FF);
        inc_case(2'h3, 1'b1, 16'h7FFF);
        $display("test_inc done");
    endtask

    task automatic blk_case(input logic wd, input logic df, input logic rep,
                            input logic [15:0] cnt, input logic [15:0] d0, input logic [3:0] wt);
        logic [15:0] v;
        logic [7:0]  c0;
        logic [15:0] n;
        logic [15:0] st;
        logic [15:0] fl;
        n = rep ? cnt : 16'h0001;
        st = wd ? mul_port_pkg::STEP_WORD : mul_port_pkg::STEP_BYTE;
        fl = {5'h00, df, 10'h3D5};
        wait_cycles <= wt;
        wr(mul_port_pkg::ADDR_DEXT, 16'h8421);
        wr(mul_port_pkg::ADDR_ESEG, 16'h3C00);
        wr(mul_port_pkg::ADDR_DPTR, d0);
        wr(mul_port_pkg::ADDR_RCNT, cnt);
        wr(mul_port_pkg::ADDR_FLAGS, fl);
        c0 = mem_count;
        run(2'h3, wd, 1'b1, rep, 2'h0, 8'h00);
        check({8'h00, mem_count - c0}, n, "transfer count");
        rd(mul_port_pkg::ADDR_DPTR, v);
        check(v, df ? d0 - n * st : d0 + n * st, "pointer step");
        if (n != 16'h0000) begin
            check(last_mem.seg, 16'h3C00, "segment");
            check(last_mem.off, df ? d0 - (n - 1) * st : d0 + (n - 1) * st, "offset");
            check(last_port, 16'h8421, "block port");
            check(wd ? last_mem.data : {8'h00, last_mem.data[7:0]},
                  wd ? 16'h477B : 16'h007B, "block data");
        end
        rd(mul_port_pkg::ADDR_FLAGS, v);
        check(v, fl, "block flags");
        rd(mul_port_pkg::ADDR_RCNT, v);
        check(v, rep ? 16'h0000 : cnt, "repeat count");
    endtask

    task automatic test_block();
        blk_case(1'b0, 1'b0, 1'b0, 16'h0005, 16'h0010, 4'h0);
        blk_case(1'b1, 1'b1, 1'b1, 16'h0003, 16'h0100, 4'h2);
        blk_case(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0020, 4'h0);
        blk_case(1'b1, 1'b0, 1'b1, 16'h0002, 16'hFFFF, 4'h1);
        blk_case(1'b0, 1'b1, 1'b1, 16'h0002, 16'h0001, 4'h0);
        $display("test_block done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        errors = 0;
        total_checks = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        wait_cycles = 4'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        test_reset();
        test_mul();
        test_in();
        test_inc();
        test_block();
        results();
    end
endmodule
`default_nettype wire
